// *** dv/bsbm_host_model.sv ***
// Purpose: host processor model issuing port and memory cycles to the card
// Assumes: one cycle at a time, inputs moved 1 ns after the rising edge
// Notes:   released address and data lines carry the inverse of the last value
`timescale 1ns/1ps
`default_nettype none
module bsbm_host_model
    import bsbm_pkg::*;
(
    input  wire logic                         clk,
    output logic [bsbm_pkg::ADDR_W-1:0]       bus_addr,
    output logic [bsbm_pkg::DATA_W-1:0]       bus_dout,
    output logic                              io_wr_stb,
    output logic                              io_rd_stb,
    output logic                              mem_rd_stb,
    output logic                              mem_wr_stb,
    input  wire logic [bsbm_pkg::DATA_W-1:0]  bus_din,
    input  wire logic                         bus_din_oe_n,
    input  wire logic                         left_rom_socket_cs,
    input  wire logic                         right_rom_socket_cs,
    input  wire logic [bsbm_pkg::SOCK_AW-1:0] sock_addr,
    input  wire logic                         sock_we
);
    // port 7 reads back nothing, so the host keeps its own copy
    logic [DATA_W-1:0] shadow_q = 8'h03;
    initial begin
        bus_addr = 24'h00_0000;
        bus_dout = 8'h00;
        {io_wr_stb, io_rd_stb, mem_rd_stb, mem_wr_stb} = 4'h0;
    end
    ////////////////////////////////////////////////////////////////////////////
    // kind: 0 port write, 1 port read, 2 memory read, 3 memory write
    task automatic cycle(input int kind, input logic [23:0] a, input logic [7:0] d,
                         output logic [22:0] res);
        @(posedge clk);
        #1;
        bus_addr = a;
        bus_dout = d;
        io_wr_stb = (kind == 0);
        io_rd_stb = (kind == 1);
        mem_rd_stb = (kind == 2);
        mem_wr_stb = (kind == 3);
        @(posedge clk);
        #1;
        {io_wr_stb, io_rd_stb, mem_rd_stb, mem_wr_stb} = 4'h0;
        bus_addr = ~a;
        bus_dout = ~d;
        res[13:0] = {sock_we, left_rom_socket_cs, right_rom_socket_cs, sock_addr};
        @(posedge clk);
        #1;
        // an undriven data bus shows the inverse, so stale bytes cannot pass
        res[22:14] = {bus_din_oe_n, bus_din_oe_n ? ~bus_din : bus_din};
    endtask
    // only the bank bit changes, group bits kept from the copy
    task automatic set_bank(input logic [7:0] port, input logic b);
        logic [22:0] res;
        shadow_q[BANK_BIT] = b;
        cycle(0, {16'h0000, port}, shadow_q, res);
    endtask
endmodule
`default_nettype wire

// *** dv/bsbm_top_tb.sv ***
// Purpose: self-checking bench for bank enable, phantom gating and boot jump
// Assumes: card at port base 48h, memory block at C000h, no extended decode
// Notes:   sockets modelled as address-derived data
`timescale 1ns/1ps
`default_nettype none
`define CHK(g, e) begin tests_run++; if ((g) !== (e)) begin error_cnt++; \
    $display("[ERR] %0t got %h exp %h", $time, (g), (e)); end end
module bsbm_top_tb;
    import bsbm_pkg::*;
    localparam logic [7:0] PORT7 = 8'h4F;
    logic clk = 1'b0, reset = 1'b1, phantom_n = 1'b1;
    logic pol_s = 1'b1, ph_s = 1'b0, boot_s = 1'b1, sock_s = 1'b1;
    logic [23:0] bus_addr;
    logic [7:0] bus_dout, bus_din, sock_rdata, sock_wdata, gsc;
    logic io_wr_stb, io_rd_stb, mem_rd_stb, mem_wr_stb, oe_n, bus_rdy, l_cs, r_cs, we, en;
    logic [10:0] sa;
    int error_cnt = 0, tests_run = 0, cyc = 0;
    logic [22:0] res;
    // unselected sockets float to a value unlike any real byte
    assign sock_rdata = (l_cs | r_cs) ? (sa[7:0] ^ {r_cs, 7'h00}) : ~sa[7:0];
    always #4 clk = ~clk;
    bsbm_top DUT (.clk(clk), .reset(reset), .io_base_strap(5'h09),
        .polarity_strap_closed(pol_s), .phantom_strap_closed(ph_s),
        .boot_strap_closed(boot_s), .socket_strap_closed(sock_s), .ext_addr_strap_on(1'b0),
        .mem_block_strap(4'hC), .mem_seg_strap(8'h00), .bus_addr(bus_addr),
        .bus_dout(bus_dout), .io_wr_stb(io_wr_stb), .io_rd_stb(io_rd_stb),
        .mem_rd_stb(mem_rd_stb), .mem_wr_stb(mem_wr_stb), .phantom_n(phantom_n),
        .bus_din(bus_din), .bus_din_oe_n(oe_n), .bus_rdy(bus_rdy), .sock_rdata(sock_rdata),
        .left_rom_socket_cs(l_cs), .right_rom_socket_cs(r_cs), .sock_addr(sa),
        .sock_we(we), .sock_wdata(sock_wdata), .group_select_control(gsc),
        .mem_enabled(en));
    bsbm_host_model host (.clk(clk), .bus_addr(bus_addr), .bus_dout(bus_dout),
        .io_wr_stb(io_wr_stb), .io_rd_stb(io_rd_stb), .mem_rd_stb(mem_rd_stb),
        .mem_wr_stb(mem_wr_stb), .bus_din(bus_din), .bus_din_oe_n(oe_n),
        .left_rom_socket_cs(l_cs), .right_rom_socket_cs(r_cs), .sock_addr(sa),
        .sock_we(we));
    ////////////////////////////////////////////////////////////////////////////
    task automatic report_and_stop();
        if (error_cnt == 0 && tests_run > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask
    always @(posedge clk) begin
        cyc++;
        if (cyc == 2000) begin
            error_cnt++;
            report_and_stop();
        end
    end
    task automatic do_reset();
        @(posedge clk);
        #1;
        reset = 1'b1;
        repeat (2) @(posedge clk);
        #1;
        reset = 1'b0;
    endtask
    // h: card answers, rt: right socket expected, s: expected socket address
    task automatic op(input int k, input logic [23:0] a, input logic h, input logic rt,
                      input logic [10:0] s);
        logic [22:0] r;
        host.cycle(k, a, 8'h5A, r);
        `CHK({r[22], r[13:11]}, {~(h && k == 2), h && k == 3, h && !rt, h && rt})
        if (h)
            `CHK(r[10:0], s)
        if (h && k == 2)
            `CHK(r[21:14], s[7:0] ^ {rt, 7'h00})
        if (h && k == 3)
            `CHK(sock_wdata, 8'h5A)
    endtask
    ////////////////////////////////////////////////////////////////////////////
    initial begin
        do_reset();
        `CHK(bus_rdy, 1'b1)
        for (int s = 1; s >= 0; s--) begin
            sock_s = s[0];
            do_reset();
            op(3, 24'h00_C000, 1'b0, 1'b0, 11'h000);
            for (int i = 0; i < 8; i++)
                op(2, 24'(24'h00_1230 + i), 1'b1, !s[0], {8'hFF, i[2:0]});
            op(2, 24'h00_1238, 1'b0, 1'b0, 11'h000);
        end
        op(2, 24'h00_C012, 1'b1, 1'b0, 11'h012);
        op(3, 24'h00_C834, 1'b1, 1'b1, 11'h034);
        op(2, 24'h00_B012, 1'b0, 1'b0, 11'h000);
        host.set_bank(PORT7, 1'b1);
        `CHK(en, 1'b0)
        `CHK(gsc, 8'h07)
        op(2, 24'h00_C012, 1'b0, 1'b0, 11'h000);
        host.cycle(0, 24'h00_004E, 8'h00, res);
        `CHK(en, 1'b0)
        host.cycle(1, {16'h0000, PORT7}, 8'h00, res);
        `CHK(res[22], 1'b1)
        host.set_bank(PORT7, 1'b0);
        `CHK(en, 1'b1)
        host.set_bank(PORT7, 1'b1);
        pol_s = 1'b0;
        #1;
        `CHK(en, 1'b1)
        do_reset();
        `CHK(en, 1'b0)
        op(2, 24'h00_1230, 1'b0, 1'b0, 11'h000);
        // the boot sequencer is still armed here, so late enabling would force fetches
        boot_s = 1'b0;
        host.set_bank(PORT7, 1'b1);
        `CHK(en, 1'b1)
        phantom_n = 1'b0;
        op(2, 24'h00_C055, 1'b1, 1'b0, 11'h055);
        ph_s = 1'b1;
        op(2, 24'h00_C055, 1'b0, 1'b0, 11'h000);
        phantom_n = 1'b1;
        op(2, 24'h00_C855, 1'b1, 1'b1, 11'h055);
        pol_s = 1'b1;
        boot_s = 1'b0;
        host.set_bank(PORT7, 1'b1);
        do_reset();
        `CHK(en, 1'b1)
        op(2, 24'h00_1230, 1'b0, 1'b0, 11'h000);
        report_and_stop();
    end
endmodule
`default_nettype wire

// *** inc/bsbm_pkg.sv ***
// Purpose: shared constants for the bank select and boot memory block
// Assumes: 8-bit host data, 24-bit host address, 2K per socket
// Notes:   the boot state type is used by the boot vector module
package bsbm_pkg;

    localparam int unsigned DATA_W      = 8;
    localparam int unsigned ADDR_W      = 24;
    localparam int unsigned IO_BASE_W   = 5;
    localparam int unsigned SOCK_AW     = 11;
    localparam int unsigned SEG_W       = 8;
    localparam int unsigned BLK_W       = 4;

    // group_select_control sits at offset 7 of the card's eight ports
    localparam logic [2:0] GSEL_OFFSET  = 3'h7;
    localparam int unsigned BANK_BIT    = 2;
    localparam logic [DATA_W-1:0] GSEL_RESET = 8'h00;

    // address field positions
    localparam int unsigned IO_OFS_LO   = 0;
    localparam int unsigned IO_OFS_HI   = 2;
    localparam int unsigned IO_BASE_LO  = 3;
    localparam int unsigned IO_BASE_HI  = 7;
    localparam int unsigned SOCK_SEL    = 11;
    localparam int unsigned BLK_LO      = 12;
    localparam int unsigned BLK_HI      = 15;
    localparam int unsigned SEG_LO      = 16;
    localparam int unsigned SEG_HI      = 23;

    // boot vector: last eight bytes of a socket
    localparam int unsigned BOOT_BYTES  = 8;
    localparam int unsigned BOOT_LOW_W  = 3;
    localparam logic [SOCK_AW-BOOT_LOW_W-1:0] BOOT_TOP = 8'hFF;
    localparam logic [3:0] BOOT_CNT_W1  = 4'h1;
    localparam logic [3:0] BOOT_CNT_0   = 4'h0;

    typedef enum logic [0:0] {
        BOOT_RUN,
        BOOT_DONE
    } bsbm_boot_t;

endpackage

// *** logic/bsbm_boot_vec.sv ***
// Purpose: power-on jump sequencer, forces the first fetches after reset
// Assumes: fetch is a one-cycle pulse per accepted forced read
// Notes:   once eight forced fetches are seen the force drops until reset
`timescale 1ns/1ps
`default_nettype none
module bsbm_boot_vec
    import bsbm_pkg::*;
#(
    parameter logic [3:0] BOOT_COUNT = 4'h8
) (
    input  wire logic clk,
    input  wire logic reset,
    input  wire logic arm,
    input  wire logic fetch,
    output logic      force_boot
);
    import bsbm_pkg::*;

    bsbm_boot_t state_q;
    bsbm_boot_t state_d;
    logic [3:0] count_q;
    logic [3:0] count_d;
    wire        last_fetch = fetch && force_boot && (count_q == BOOT_COUNT - BOOT_CNT_W1);

    always_comb begin
        state_d = state_q;
        count_d = count_q;
        case (state_q)
            BOOT_RUN: begin
                if (fetch && force_boot) begin
                    count_d = count_q + BOOT_CNT_W1;
                end
                if (last_fetch) begin
                    state_d = BOOT_DONE;
                end
            end
            BOOT_DONE: begin
                count_d = count_q;
            end
            default: begin
                state_d = BOOT_DONE;
            end
        endcase
    end

    always_ff @(posedge clk) begin
        if (reset) begin
            state_q <= BOOT_RUN;
            count_q <= BOOT_CNT_0;
        end else begin
            state_q <= state_d;
            count_q <= count_d;
        end
    end

    // force only while armed; a disabled bank never serves boot bytes
    assign force_boot = arm && (state_q == BOOT_RUN);

    a_boot_stops: assert property (@(posedge clk) disable iff (reset)
        last_fetch |=> !force_boot [*3])
        else $error("boot force still active after last fetch");

endmodule
`default_nettype wire

// *** logic/bsbm_top.sv ***
// Purpose: bank enable, phantom gating, memory decode and power-on jump
// Assumes: bus strobes are one-cycle pulses synchronous to clk
// Notes:   straps are static levels; sockets are external, read combinationally
//
// Function
// - A write to port offset 7, any group, samples data bit 2 for bank enable.
// - Polarity strap closed: enabled after reset; bit 2 low enables, high disables.
// - Polarity strap open: disabled after reset; bit 2 high enables memory.
// - Polarity strap closed: disabled memory stays silent until reset, bit 2 low write, or strap opened.
// - Deselected memory drives no data and gives no acknowledge on the bus.
// - Bank enable gates only memory decode, never the card's I/O ports.
// - Reading port offset 7 returns nothing; the register is write-only.
// - Phantom strap open: phantom signal is ignored by the decode.
// - Phantom strap closed: memory silent while phantom is active.
// - Boot strap on: fetches after reset go to last eight socket bytes.
// - Socket strap picks boot socket: closed is left, open is right.
// - Boot jump serves own memory only, and only while memory is enabled.
// - Memory is one 4K unit on a strapped boundary, left low, right high.
// - Memory accesses never insert wait states.
`timescale 1ns/1ps
`default_nettype none
module bsbm_top
    import bsbm_pkg::*;
#(
    parameter logic [3:0] BOOT_COUNT = 4'h8
) (
    input  wire logic                         clk,
    input  wire logic                         reset,
    // straps, closed reads as 1
    input  wire logic [bsbm_pkg::IO_BASE_W-1:0] io_base_strap,
    input  wire logic                         polarity_strap_closed,
    input  wire logic                         phantom_strap_closed,
    input  wire logic                         boot_strap_closed,
    input  wire logic                         socket_strap_closed,
    input  wire logic                         ext_addr_strap_on,
    input  wire logic [bsbm_pkg::BLK_W-1:0]   mem_block_strap,
    input  wire logic [bsbm_pkg::SEG_W-1:0]   mem_seg_strap,
    // host bus
    input  wire logic [bsbm_pkg::ADDR_W-1:0]  bus_addr,
    input  wire logic [bsbm_pkg::DATA_W-1:0]  bus_dout,
    input  wire logic                         io_wr_stb,
    input  wire logic                         io_rd_stb,
    input  wire logic                         mem_rd_stb,
    input  wire logic                         mem_wr_stb,
    input  wire logic                         phantom_n,
    output logic [bsbm_pkg::DATA_W-1:0]       bus_din,
    output logic                              bus_din_oe_n,
    output logic                              bus_rdy,
    // sockets
    input  wire logic [bsbm_pkg::DATA_W-1:0]  sock_rdata,
    output logic                              left_rom_socket_cs,
    output logic                              right_rom_socket_cs,
    output logic [bsbm_pkg::SOCK_AW-1:0]      sock_addr,
    output logic                              sock_we,
    output logic [bsbm_pkg::DATA_W-1:0]       sock_wdata,
    // state
    output logic [bsbm_pkg::DATA_W-1:0]       group_select_control,
    output logic                              mem_enabled
);
    import bsbm_pkg::*;

    ////////////////////////////////////////////////////////////////////////////
    // decode

    function automatic logic port_hit(input logic [ADDR_W-1:0] a,
                                      input logic [IO_BASE_W-1:0] base,
                                      input logic [2:0] ofs);
        port_hit = (a[IO_BASE_HI:IO_BASE_LO] == base) && (a[IO_OFS_HI:IO_OFS_LO] == ofs);
    endfunction

    logic [DATA_W-1:0]  gsel_q;
    logic [DATA_W-1:0]  gsel_d;
    logic               force_boot;

    // only offset 7 is decoded here, whatever group is active
    wire gsel_wr = io_wr_stb && port_hit(bus_addr, io_base_strap, GSEL_OFFSET);
    wire gsel_rd = io_rd_stb && port_hit(bus_addr, io_base_strap, GSEL_OFFSET);

    // bit stored raw; the strap sets its sense, so reset value 0 works both ways
    wire bank_bit = gsel_q[BANK_BIT];
    assign mem_enabled = polarity_strap_closed ? !bank_bit : bank_bit;

    wire phantom_block = phantom_strap_closed && !phantom_n;

    wire blk_match = (bus_addr[BLK_HI:BLK_LO] == mem_block_strap);
    wire seg_match = !ext_addr_strap_on || (bus_addr[SEG_HI:SEG_LO] == mem_seg_strap);
    wire addr_match = blk_match && seg_match;

    wire boot_arm = boot_strap_closed && mem_enabled && !phantom_block;
    wire decode_ok = mem_enabled && !phantom_block;
    wire mem_hit = decode_ok && (force_boot || addr_match);

    // boot reads land on the strapped socket's top eight bytes
    wire boot_left = socket_strap_closed;
    wire sel_left = force_boot ? boot_left : !bus_addr[SOCK_SEL];
    wire [SOCK_AW-1:0] boot_addr = {BOOT_TOP, bus_addr[BOOT_LOW_W-1:0]};
    wire [SOCK_AW-1:0] next_addr = force_boot ? boot_addr : bus_addr[SOCK_AW-1:0];

    wire rd_take = mem_rd_stb && mem_hit;
    wire wr_take = mem_wr_stb && mem_hit && !force_boot;
    wire boot_fetch = mem_rd_stb && force_boot && mem_hit;

    always_comb begin
        gsel_d = gsel_q;
        if (gsel_wr) begin
            gsel_d = bus_dout;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // registers

    logic                cs_left_q;
    logic                cs_right_q;
    logic [SOCK_AW-1:0]  sock_addr_q;
    logic                sock_we_q;
    logic [DATA_W-1:0]   sock_wdata_q;
    logic                rd_pend_q;
    logic [DATA_W-1:0]   din_q;
    logic                din_vld_q;

    always_ff @(posedge clk) begin
        if (reset) begin
            gsel_q <= GSEL_RESET;
        end else begin
            gsel_q <= gsel_d;
        end
    end

    // socket access runs for one cycle after the strobe
    always_ff @(posedge clk) begin
        if (reset) begin
            cs_left_q    <= 1'b0;
            cs_right_q   <= 1'b0;
            sock_we_q    <= 1'b0;
            rd_pend_q    <= 1'b0;
            sock_addr_q  <= '0;
            sock_wdata_q <= '0;
        end else begin
            cs_left_q  <= (rd_take || wr_take) && sel_left;
            cs_right_q <= (rd_take || wr_take) && !sel_left;
            sock_we_q  <= wr_take;
            rd_pend_q  <= rd_take;
            if (rd_take || wr_take) begin
                sock_addr_q  <= next_addr;
                sock_wdata_q <= bus_dout;
            end
        end
    end

    // read data is registered; no drive for port 7 reads or misses
    always_ff @(posedge clk) begin
        if (reset) begin
            din_q     <= '0;
            din_vld_q <= 1'b0;
        end else begin
            din_vld_q <= rd_pend_q;
            if (rd_pend_q) begin
                din_q <= sock_rdata;
            end
        end
    end

    bsbm_boot_vec #(
        .BOOT_COUNT (BOOT_COUNT)
    ) u_boot (
        .clk        (clk),
        .reset      (reset),
        .arm        (boot_arm),
        .fetch      (boot_fetch),
        .force_boot (force_boot)
    );

    ////////////////////////////////////////////////////////////////////////////
    // outputs

    assign left_rom_socket_cs   = cs_left_q;
    assign right_rom_socket_cs  = cs_right_q;
    assign sock_addr            = sock_addr_q;
    assign sock_we              = sock_we_q;
    assign sock_wdata           = sock_wdata_q;
    assign bus_din              = din_q;
    assign bus_din_oe_n         = !din_vld_q;
    // fixed-latency path, the card never asks for wait states
    assign bus_rdy              = 1'b1;
    assign group_select_control = gsel_q;

    ////////////////////////////////////////////////////////////////////////////
    // checks

    a_gsel_sample: assert property (@(posedge clk) disable iff (reset)
        gsel_wr |=> group_select_control[BANK_BIT] == $past(bus_dout[BANK_BIT]))
        else $error("bank bit not sampled from port 7 write");

    a_reset_on_closed: assert property (@(posedge clk)
        $past(reset) && !reset && polarity_strap_closed |-> mem_enabled)
        else $error("memory not enabled after reset with strap closed");

    a_reset_off_open: assert property (@(posedge clk)
        $past(reset) && !reset && !polarity_strap_closed |-> !mem_enabled)
        else $error("memory enabled after reset with strap open");

    a_disable_holds: assert property (@(posedge clk) disable iff (reset)
        polarity_strap_closed && !mem_enabled && !gsel_wr
        |=> polarity_strap_closed |-> !mem_enabled)
        else $error("disabled memory re-enabled without cause");

    a_deselect_quiet: assert property (@(posedge clk) disable iff (reset)
        mem_rd_stb && !mem_enabled && !$past(rd_pend_q) && !rd_pend_q
        |=> !left_rom_socket_cs && !right_rom_socket_cs ##1 bus_din_oe_n)
        else $error("deselected memory answered");

    a_other_port_keep: assert property (@(posedge clk) disable iff (reset)
        io_wr_stb && !gsel_wr |=> $stable(group_select_control))
        else $error("write to another port changed group select");

    a_port7_silent: assert property (@(posedge clk) disable iff (reset)
        gsel_rd && !rd_pend_q && !rd_take |=> ##1 bus_din_oe_n)
        else $error("port 7 read drove the bus");

    a_phantom_block: assert property (@(posedge clk) disable iff (reset)
        mem_rd_stb && phantom_strap_closed && !phantom_n
        |=> !left_rom_socket_cs && !right_rom_socket_cs)
        else $error("memory answered while phantom active");

    a_boot_top_addr: assert property (@(posedge clk) disable iff (reset)
        boot_fetch |=> sock_addr[SOCK_AW-1:BOOT_LOW_W] == BOOT_TOP
                       && left_rom_socket_cs == $past(socket_strap_closed))
        else $error("boot fetch not steered to strapped socket top");

    a_no_wait: assert property (@(posedge clk) disable iff (reset)
        rd_take |-> bus_rdy ##1 (bus_rdy && (left_rom_socket_cs || right_rom_socket_cs))
                    ##1 (bus_rdy && !bus_din_oe_n))
        else $error("memory read latency or ready broken");

    // enable sense is checked only while the strap holds still across the write
    a_sense_closed: assert property (@(posedge clk) disable iff (reset)
        gsel_wr && polarity_strap_closed ##1 polarity_strap_closed
        |-> mem_enabled == !$past(bus_dout[BANK_BIT]))
        else $error("closed strap bank bit sense wrong");

    a_sense_open: assert property (@(posedge clk) disable iff (reset)
        gsel_wr && !polarity_strap_closed ##1 !polarity_strap_closed
        |-> mem_enabled == $past(bus_dout[BANK_BIT]))
        else $error("open strap bank bit sense wrong");

    a_phantom_ignored: assert property (@(posedge clk) disable iff (reset)
        mem_rd_stb && !phantom_strap_closed && mem_enabled && addr_match
        |=> left_rom_socket_cs || right_rom_socket_cs)
        else $error("phantom blocked memory with strap open");

    a_right_upper: assert property (@(posedge clk) disable iff (reset)
        rd_take && !force_boot |=> right_rom_socket_cs == $past(bus_addr[SOCK_SEL]))
        else $error("socket half not chosen by address bit 11");

    a_boot_no_write: assert property (@(posedge clk) disable iff (reset)
        mem_wr_stb && force_boot |=> !sock_we)
        else $error("socket written during boot force");

endmodule
`default_nettype wire
